//--- rtl/capture_pkg.sv
// Shared constants for the edge capture unit and its companion timer end
package capture_pkg;
    // Width of the companion timer count and the capture value pair
    localparam int COUNT_W = 16;
    // Control register fields: enable in bit 7, event select in bits 3:0
    localparam int CTRL_EN_BIT = 7;
    localparam int MODE_W = 4;
    localparam int SRC_W = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] SRC_RESET = 3'h0;
    // Event select encodings for capture modes
    localparam logic [3:0] MODE_FALL = 4'h4;
    localparam logic [3:0] MODE_RISE = 4'h5;
    localparam logic [3:0] MODE_RISE4 = 4'h6;
    localparam logic [3:0] MODE_RISE16 = 4'h7;
    // Prescaler counter width and terminal counts
    localparam int PRE_W = 4;
    localparam logic [3:0] PRE_LAST4 = 4'h3;
    localparam logic [3:0] PRE_LAST16 = 4'hf;
    localparam logic [3:0] PRE_ZERO = 4'h0;
    // Capture source select codes
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_CMP1 = 3'h1;
    localparam logic [2:0] SRC_CMP2 = 3'h2;
    localparam logic [2:0] SRC_IOC = 3'h3;
    localparam logic [2:0] SRC_LC1 = 3'h4;
    localparam logic [2:0] SRC_LC2 = 3'h5;
    localparam logic [2:0] SRC_LC3 = 3'h6;
    localparam logic [2:0] SRC_LC4 = 3'h7;
endpackage

//--- rtl/capture_if.sv
// Interface joining the capture unit and the companion timer end
`timescale 1ns/10ps
`default_nettype none
interface capture_if;
    logic [15:0] timer_count;
    logic timer_valid;
    logic capture_strobe;
    modport unit (input timer_count, input timer_valid, output capture_strobe);
    modport timer (output timer_count, output timer_valid, input capture_strobe);
endinterface
`default_nettype wire

//--- rtl/edge_sync.sv
// Three-stage synchroniser with one-cycle rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Asynchronous level
    input wire logic level_in,
    // Edge pulses
    output logic rise_out,
    output logic fall_out
);
    logic [2:0] stage;

    // First stage feeds only the second; second and third decide edges
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], level_in};
        end
    end

    // A change counts once stages two and three disagree for one cycle
    assign rise_out = stage[1] & ~stage[2];
    assign fall_out = ~stage[1] & stage[2];
endmodule // edge_sync
`default_nettype wire

//--- rtl/edge_capture_unit.sv
// Capture unit: source select, edge prescale, latching of timer count
`timescale 1ns/10ps
`default_nettype none
// Function
// - Event loads full 16-bit timer count
// - Mode picks fall, rise, 4th, 16th rise
// - Capture sets flag; only software clears
// - New capture overwrites stored pair
// - Three-bit field selects one of eight sources
// - Pin level watched even when driven
// - Timer must run synchronous for valid capture
// - Timer counts slower than system clock
// - Mode change may set false flag
// - Prescaler cleared when off, noncapture, reset
// - Prescale switch keeps counter, may falsely flag
module edge_capture_unit (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    // Timer link
    capture_if.unit LINK,
    // Control written by software
    input wire logic [7:0] CONTROL_IN,
    input wire logic CONTROL_WE_IN,
    input wire logic [2:0] SOURCE_IN,
    input wire logic SOURCE_WE_IN,
    input wire logic FLAG_CLEAR_IN,
    // Capture sources
    input wire logic PIN_LEVEL_IN,
    input wire logic CMP_ONE_SYNC_IN,
    input wire logic CMP_TWO_SYNC_IN,
    input wire logic PIN_CHANGE_IN,
    input wire logic [3:0] LOGIC_CELL_IN,
    // Status and captured value
    output logic [7:0] CONTROL_OUT,
    output logic [2:0] SOURCE_OUT,
    output logic [15:0] CAPTURE_VALUE_OUT,
    output logic CAPTURE_FLAG_OUT
);
    logic [7:0] control;
    logic [2:0] source;
    logic [3:0] prescale;
    logic selected;
    logic rise;
    logic fall;
    logic enabled;
    logic is_capture;
    logic event_hit;
    logic [15:0] value;
    logic flag;

    // Test whether a mode code is one of the capture modes
    function automatic logic capture_mode(input logic [3:0] m);
        capture_mode = (m == capture_pkg::MODE_FALL) || (m == capture_pkg::MODE_RISE) ||
                       (m == capture_pkg::MODE_RISE4) || (m == capture_pkg::MODE_RISE16);
    endfunction

    // Software control registers
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            control <= capture_pkg::CTRL_RESET;
        end else if (CONTROL_WE_IN) begin
            control <= CONTROL_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            source <= capture_pkg::SRC_RESET;
        end else if (SOURCE_WE_IN) begin
            source <= SOURCE_IN;
        end
    end

    // Source mux; the pin is read as a level whatever drives it
    always_comb begin
        case (source)
            capture_pkg::SRC_PIN: selected = PIN_LEVEL_IN;
            capture_pkg::SRC_CMP1: selected = CMP_ONE_SYNC_IN;
            capture_pkg::SRC_CMP2: selected = CMP_TWO_SYNC_IN;
            capture_pkg::SRC_IOC: selected = PIN_CHANGE_IN;
            capture_pkg::SRC_LC1: selected = LOGIC_CELL_IN[0];
            capture_pkg::SRC_LC2: selected = LOGIC_CELL_IN[1];
            capture_pkg::SRC_LC3: selected = LOGIC_CELL_IN[2];
            capture_pkg::SRC_LC4: selected = LOGIC_CELL_IN[3];
            default: selected = PIN_LEVEL_IN;
        endcase
    end

    // Synchronise after the mux; a source switch can look like an edge
    edge_sync u_sync (
        .clk_in(CLK_SYS_IN),
        .rstn_in(RSTN_IN),
        .level_in(selected),
        .rise_out(rise),
        .fall_out(fall)
    );

    assign enabled = control[capture_pkg::CTRL_EN_BIT];
    assign is_capture = capture_mode(control[capture_pkg::MODE_W-1:0]);

    // Qualify edges against the prescale setting
    always_comb begin
        case (control[capture_pkg::MODE_W-1:0])
            capture_pkg::MODE_FALL: event_hit = fall;
            capture_pkg::MODE_RISE: event_hit = rise;
            capture_pkg::MODE_RISE4: event_hit = rise && (prescale == capture_pkg::PRE_LAST4);
            capture_pkg::MODE_RISE16: event_hit = rise && (prescale == capture_pkg::PRE_LAST16);
            default: event_hit = 1'b0;
        endcase
        event_hit = event_hit && enabled;
    end

    // Prescaler counts rising edges; switches between capture modes leave it alone
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            prescale <= capture_pkg::PRE_ZERO;
        end else if (!enabled || !is_capture) begin
            prescale <= capture_pkg::PRE_ZERO;
        end else if (event_hit && rise) begin
            prescale <= capture_pkg::PRE_ZERO;
        end else if (rise) begin
            prescale <= prescale + 4'h1;
        end
    end

    // Latch the whole count, overwriting any unread value
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            value <= 16'h0000;
        end else if (event_hit) begin
            value <= LINK.timer_count;
        end
    end

    // Flag: set wins over a software clear in the same cycle
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            flag <= 1'b0;
        end else if (event_hit) begin
            flag <= 1'b1;
        end else if (FLAG_CLEAR_IN) begin
            flag <= 1'b0;
        end
    end

    assign LINK.capture_strobe = event_hit;
    assign CONTROL_OUT = control;
    assign SOURCE_OUT = source;
    assign CAPTURE_VALUE_OUT = value;
    assign CAPTURE_FLAG_OUT = flag;
endmodule // edge_capture_unit
`default_nettype wire

//--- rtl/companion_timer.sv
// Companion timer end: 16-bit counter on an enable pulse from a divider
`timescale 1ns/10ps
`default_nettype none
module companion_timer #(
    parameter int DIVIDE = 4
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    // Timer link
    capture_if.timer LINK,
    // User side
    input wire logic RUN_IN,
    output logic [15:0] COUNT_OUT,
    output logic STROBE_SEEN_OUT
);
    logic [7:0] div;
    logic tick;
    logic [15:0] count;

    // Counting below the system rate keeps captures meaningful
    assign tick = (div == 8'(DIVIDE - 1));

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            div <= 8'h00;
        end else if (tick || !RUN_IN) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    // Synchronous counter on the system clock
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            count <= 16'h0000;
        end else if (RUN_IN && tick) begin
            count <= count + 16'h0001;
        end
    end

    assign LINK.timer_count = count;
    assign LINK.timer_valid = RUN_IN;
    assign COUNT_OUT = count;
    assign STROBE_SEEN_OUT = LINK.capture_strobe;
endmodule // companion_timer
`default_nettype wire

//--- tb/edge_capture_unit_checker.sv
// Checker on the link between the capture unit and its timer
`timescale 1ns/10ps
`default_nettype none
module edge_capture_unit_checker (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    // Link signals
    input wire logic [15:0] timer_count,
    input wire logic timer_valid,
    input wire logic capture_strobe
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);
    // A held level must not give a second strobe
    property p_one_strobe;
        capture_strobe |=> !capture_strobe;
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("strobe too long");
    // Count only ever steps by one
    property p_count_step;
        $changed(timer_count) |-> timer_count == $past(timer_count) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count jumped");
    // Divider of four keeps the count below the system rate
    property p_count_slow;
        $changed(timer_count) |=> $stable(timer_count)[*3];
    endproperty
    a_count_slow: assert property (p_count_slow) else $error("count too fast");
    // A stopped timer holds its count
    property p_count_hold;
        !timer_valid ##1 !timer_valid |-> $stable(timer_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("stopped count moved");
    // The count only moves while the timer reports itself running
    property p_count_running;
        $changed(timer_count) |-> $past(timer_valid);
    endproperty
    a_count_running: assert property (p_count_running) else $error("count moved while stopped");
    // Edge pulses last one cycle; strobes must be at least three cycles apart
    property p_strobe_gap;
        capture_strobe |=> !capture_strobe ##1 !capture_strobe;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
    // Main scenarios reached
    c_strobe: cover property (capture_strobe);
    c_live: cover property (timer_valid && capture_strobe);
    c_step: cover property ($changed(timer_count));
endmodule // edge_capture_unit_checker
`default_nettype wire

//--- tb/edge_capture_unit_test.sv
// Bench joining the capture unit and its timer
`timescale 1ns/10ps
`default_nettype none
module edge_capture_unit_test;
    logic clk, rstn, we, swe, clr, run;
    logic [7:0] ctl, srcs;
    logic [2:0] src;
    logic [15:0] seen;
    int n_cap = 0, err_total = 0, checks_done = 0;
    wire logic [7:0] ctl_o;
    wire logic [2:0] src_o;
    wire logic [15:0] cap_o;
    wire logic flag_o;
    wire logic [15:0] cnt_o;
    wire logic seen_o;
    capture_if capture_if_i ();
    edge_capture_unit edge_capture_unit_i (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
        .LINK(capture_if_i), .CONTROL_IN(ctl), .CONTROL_WE_IN(we), .SOURCE_IN(src),
        .SOURCE_WE_IN(swe), .FLAG_CLEAR_IN(clr), .PIN_LEVEL_IN(srcs[0]),
        .CMP_ONE_SYNC_IN(srcs[1]), .CMP_TWO_SYNC_IN(srcs[2]), .PIN_CHANGE_IN(srcs[3]),
        .LOGIC_CELL_IN(srcs[7:4]), .CONTROL_OUT(ctl_o), .SOURCE_OUT(src_o),
        .CAPTURE_VALUE_OUT(cap_o), .CAPTURE_FLAG_OUT(flag_o));
    companion_timer #(.DIVIDE(4)) companion_timer_i (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
        .LINK(capture_if_i), .RUN_IN(run), .COUNT_OUT(cnt_o), .STROBE_SEEN_OUT(seen_o));
    edge_capture_unit_checker chk_i (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
        .timer_count(capture_if_i.timer_count), .timer_valid(capture_if_i.timer_valid),
        .capture_strobe(capture_if_i.capture_strobe));
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Count at each strobe is what the unit must latch
    always @(posedge clk) begin
        if (seen_o === 1'b1) begin
            seen <= cnt_o;
            n_cap <= n_cap + 1;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Write control (sel low) or source (sel high)
    task automatic wr(input logic sel, input logic [7:0] v);
        @(posedge clk);
        ctl <= v;
        src <= v[2:0];
        we <= !sel;
        swe <= sel;
        @(posedge clk);
        we <= 1'b0;
        swe <= 1'b0;
        @(posedge clk);
    endtask
    // Levels held four cycles so the synchroniser sees each one
    task automatic pulse(input int s, input int n);
        repeat (n) begin
            @(posedge clk);
            srcs[s] <= 1'b1;
            repeat (4) @(posedge clk);
            srcs[s] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    initial begin
        {rstn, we, swe, clr, run} = 5'h00;
        ctl = 8'h00;
        src = 3'h0;
        srcs = 8'h00;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({8'h00, ctl_o}, 16'h0000);
        chk({15'h0000, flag_o}, 16'h0000);
        run <= 1'b1;
        wr(1'b0, 8'h85);
        chk({8'h00, ctl_o}, 16'h0085);
        pulse(0, 1);
        chk(cap_o, seen);
        chk(16'(n_cap), 16'h0001);
        chk({15'h0000, flag_o}, 16'h0001);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        chk({15'h0000, flag_o}, 16'h0000);
        wr(1'b0, 8'h84);
        pulse(0, 1);
        chk(16'(n_cap), 16'h0002);
        chk(cap_o, seen);
        // Falling mode counted a rise; turn off first so the switch starts clean
        wr(1'b0, 8'h00);
        wr(1'b0, 8'h86);
        pulse(0, 3);
        chk(16'(n_cap), 16'h0002);
        pulse(0, 3);
        chk(16'(n_cap), 16'h0003);
        // Disable clears the partial prescale count
        wr(1'b0, 8'h00);
        wr(1'b0, 8'h86);
        pulse(0, 3);
        chk(16'(n_cap), 16'h0003);
        pulse(0, 1);
        chk(16'(n_cap), 16'h0004);
        wr(1'b0, 8'h87);
        pulse(0, 15);
        chk(16'(n_cap), 16'h0004);
        pulse(0, 1);
        chk(16'(n_cap), 16'h0005);
        wr(1'b0, 8'h83);
        pulse(0, 1);
        wr(1'b0, 8'h05);
        pulse(0, 1);
        chk(16'(n_cap), 16'h0005);
        wr(1'b0, 8'h85);
        for (int s = 0; s < 8; s++) begin
            wr(1'b1, 8'(s));
            chk({13'h0000, src_o}, 16'(s));
            pulse(s, 1);
            chk(16'(n_cap), 16'(6 + s));
        end
        final_report;
    end
endmodule // edge_capture_unit_test
`default_nettype wire
